// *** hdl/i2c_register_access_port.sv ***
// serial target port giving a host byte access to internal 8-bit registers.
// assumes scl and sda arrive asynchronously from pins; register writes leave
// through a small fifo, reads use a request strobe and a data input.
`timescale 1ns/100ps
`default_nettype none
`include "i2c_port_map.svh"

module i2c_register_access_port
  import i2c_port_pkg::*;
#(
  parameter bit ALT_VARIANT = 1'b0
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             wr_valid,
  input  wire logic        wr_ready,
  output logic [7:0]       wr_addr,
  output logic [7:0]       wr_data,
  output logic             rd_req,
  output logic [7:0]       rd_addr,
  input  wire logic [7:0]  rd_data,
  output logic             update_hold,
  output logic             busy
);

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers and bus conditions

  logic scl_s1_reg, scl_s2_reg, scl_d_reg;
  logic sda_s1_reg, sda_s2_reg, sda_d_reg;
  logic scl_rise, scl_fall, start_cond, stop_cond;

  // three samples per edge leave wide margin at a 1 MHz bus clock
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_d_reg  <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_d_reg  <= 1'b1;
    end else begin
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg  <= scl_s2_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg  <= sda_s2_reg;
    end
  end

  assign scl_rise   = scl_s2_reg && !scl_d_reg;
  assign scl_fall   = !scl_s2_reg && scl_d_reg;
  assign start_cond = scl_s2_reg && scl_d_reg && !sda_s2_reg && sda_d_reg;
  assign stop_cond  = scl_s2_reg && scl_d_reg && sda_s2_reg && !sda_d_reg;

  //////////////////////////////////////////////////////////////////////////
  // helpers

  localparam logic [6:0] OWN_ADDR =
    ALT_VARIANT ? `TARGET_ADDR_ALT : `TARGET_ADDR_STD;

  function automatic logic in_queue(input logic [7:0] p);
    in_queue = (p >= `QUEUE_FIRST) && (p <= `QUEUE_LAST);
  endfunction

  function automatic logic is_ack_state(input port_state_t s);
    is_ack_state = (s == ST_ADDR_ACK) || (s == ST_PTR_ACK) ||
                   (s == ST_WDATA_ACK);
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // byte state machine

  port_state_t state_reg;
  logic [7:0]  shift_reg;
  logic [3:0]  cnt_reg;
  logic        rw_reg;
  logic [7:0]  ptr_reg;
  logic [7:0]  tx_reg;
  logic        byte_done;
  logic        fifo_in_ready;
  logic        push;

  assign byte_done = scl_fall && (cnt_reg == `BITS_PER_BYTE);
  assign push      = byte_done && (state_reg == ST_WDATA) && fifo_in_ready;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= 4'h0;
      shift_reg <= 8'h00;
      rw_reg    <= 1'b0;
    end else if (start_cond) begin
      state_reg <= ST_ADDR;
      cnt_reg   <= 4'h0;
    end else if (stop_cond) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
        end
        ST_ADDR, ST_PTR, ST_WDATA: begin
          if (scl_rise) begin
            shift_reg <= {shift_reg[6:0], sda_s2_reg};
            cnt_reg   <= cnt_reg + 4'h1;
          end
          if (byte_done) begin
            if (state_reg == ST_ADDR) begin
              // a foreign address drops out until the next start
              if (shift_reg[7:1] == OWN_ADDR) begin
                state_reg <= ST_ADDR_ACK;
                rw_reg    <= shift_reg[0];
              end else begin
                state_reg <= ST_IDLE;
              end
            end else if (state_reg == ST_PTR) begin
              state_reg <= ST_PTR_ACK;
            end else if (fifo_in_ready) begin
              state_reg <= ST_WDATA_ACK;
            end else begin
              // fifo full: not-acknowledge and drop out until the next start
              state_reg <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            cnt_reg   <= 4'h0;
            state_reg <= rw_reg ? ST_RDATA : ST_PTR;
          end
        end
        ST_PTR_ACK, ST_WDATA_ACK: begin
          if (scl_fall) begin
            cnt_reg   <= 4'h0;
            state_reg <= ST_WDATA;
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            cnt_reg <= cnt_reg + 4'h1;
          end
          if (byte_done) begin
            state_reg <= ST_RACK;
          end
        end
        ST_RACK: begin
          if (scl_rise && sda_s2_reg) begin
            state_reg <= ST_IDLE;
          end else if (scl_fall) begin
            cnt_reg   <= 4'h0;
            state_reg <= ST_RDATA;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // register pointer and read fetch

  // fetch at the rise of the acknowledge bit so data is ready by the fall
  assign rd_req = scl_rise && !start_cond &&
                  (((state_reg == ST_ADDR_ACK) && rw_reg) ||
                   ((state_reg == ST_RACK) && !sda_s2_reg));
  assign rd_addr = ptr_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_reg <= 8'h00;
    end else if (byte_done && (state_reg == ST_PTR) && !start_cond &&
                 !stop_cond) begin
      ptr_reg <= shift_reg;
    end else if (push || rd_req) begin
      ptr_reg <= ptr_reg + `PTR_STEP;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_reg <= 8'h00;
    end else if (scl_fall && ((state_reg == ST_ADDR_ACK && rw_reg) ||
                              state_reg == ST_RACK)) begin
      tx_reg <= rd_data;
    end else if (scl_fall && state_reg == ST_RDATA && !byte_done) begin
      tx_reg <= {tx_reg[6:0], 1'b0};
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // data line drive

  logic sda_oe_reg;

  // open drain: the line is only ever pulled low
  assign sda_out = 1'b0;
  assign sda_oe  = sda_oe_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      sda_oe_reg <= 1'b0;
    end else begin
      sda_oe_reg <= is_ack_state(state_reg) ||
                    ((state_reg == ST_RDATA) && !tx_reg[7]);
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // write fifo

  word_fifo #(
    .WIDTH (`WR_WORD_W),
    .DEPTH (`WR_FIFO_DEPTH)
  ) u_wr_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push),
    .in_ready  (fifo_in_ready),
    .in_data   ({ptr_reg, shift_reg}),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  ({wr_addr, wr_data})
  );

  //////////////////////////////////////////////////////////////////////////
  // transaction activity and update hold

  logic       busy_reg;
  logic       hold_reg;
  logic [9:0] idle_cnt_reg;
  logic       stalled;

  assign busy        = busy_reg;
  assign update_hold = hold_reg;
  // a stalled host must not defer event updates forever
  assign stalled     = (idle_cnt_reg == `DEFER_CYC);

  always_ff @(posedge clk) begin
    if (rst) begin
      busy_reg <= 1'b0;
    end else if (start_cond) begin
      busy_reg <= 1'b1;
    end else if (stop_cond) begin
      busy_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      idle_cnt_reg <= 10'h000;
    end else if (!busy_reg || scl_rise || scl_fall) begin
      idle_cnt_reg <= 10'h000;
    end else if (!stalled) begin
      idle_cnt_reg <= idle_cnt_reg + 10'h001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      hold_reg <= 1'b0;
    end else begin
      hold_reg <= busy_reg && in_queue(ptr_reg) && !stalled;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_foreign_addr: assert property (
    $rose(state_reg == ST_ADDR_ACK) |-> $past(shift_reg[7:1]) == OWN_ADDR)
    else $error("acknowledged a foreign address");
  a_addr_ack: assert property (
    state_reg == ST_ADDR_ACK && !start_cond |=> sda_oe)
    else $error("address not acknowledged");
  a_ptr_ack: assert property (
    state_reg == ST_PTR_ACK && !start_cond |=> sda_oe)
    else $error("pointer byte not acknowledged");
  a_data_ack: assert property (
    push ##1 (state_reg == ST_WDATA_ACK) |=> sda_oe)
    else $error("write byte not acknowledged");
  a_wr_ptr_step: assert property (
    push |=> ptr_reg == $past(ptr_reg) + `PTR_STEP)
    else $error("pointer did not advance after write");
  a_rd_ptr_step: assert property (
    rd_req |=> ptr_reg == $past(ptr_reg) + `PTR_STEP)
    else $error("pointer did not advance after read");
  a_read_drive: assert property (
    state_reg == ST_RDATA && $stable(state_reg) |=> sda_oe == !$past(tx_reg[7]))
    else $error("read bit not driven from shift register");
  a_hold_queue: assert property (
    busy_reg && in_queue(ptr_reg) && !stalled |=> update_hold)
    else $error("queue updates not held during access");
  a_hold_release: assert property (
    stop_cond |=> ##1 !update_hold)
    else $error("update hold outlived the transfer");
  a_idle_bound: assert property (
    idle_cnt_reg <= `DEFER_CYC)
    else $error("stall counter overran");

  c_write: cover property (push ##[1:1000] stop_cond);
  c_read_multi: cover property (rd_req ##[1:1000] rd_req);
  c_fifo_full: cover property (!fifo_in_ready && busy_reg);
  c_hold: cover property ($rose(update_hold));

endmodule

`default_nettype wire

// *** hdl/i2c_port_map.svh ***
// constants for the serial register access port: target addresses, pointer
// range of the event queue, fifo shape and timing figures.
// assumes the includer has switched implicit nets off as it sees fit.
`ifndef I2C_PORT_MAP_SVH
`define I2C_PORT_MAP_SVH

`define TARGET_ADDR_STD  7'h34
`define TARGET_ADDR_ALT  7'h30
`define QUEUE_FIRST      8'h02
`define QUEUE_LAST       8'h12
`define PTR_STEP         8'h01
`define BITS_PER_BYTE    4'h8
`define WR_WORD_W        16
`define WR_FIFO_DEPTH    4
`define CLK_MHZ          25
`define DEFER_US         23
`define DEFER_CYC        10'((`DEFER_US) * (`CLK_MHZ))

`endif

// *** hdl/i2c_port_pkg.sv ***
// types shared by the serial register access port.
// assumes nothing of its surroundings.
package i2c_port_pkg;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_PTR      = 4'h3,
    ST_PTR_ACK  = 4'h4,
    ST_WDATA    = 4'h5,
    ST_WDATA_ACK = 4'h6,
    ST_RDATA    = 4'h7,
    ST_RACK     = 4'h8
  } port_state_t;

endpackage

// *** hdl/word_fifo.sv ***
// small synchronous fifo with valid/ready on both sides.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none

module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_reg[rd_ptr_reg];

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wrap_inc(wr_ptr_reg);
      end
      if (pop) begin
        rd_ptr_reg <= wrap_inc(rd_ptr_reg);
      end
      if (push && !pop) begin
        count_reg <= count_reg + (AW+1)'(1);
      end else if (pop && !push) begin
        count_reg <= count_reg - (AW+1)'(1);
      end
    end
  end

endmodule

`default_nettype wire

// *** dv/i2c_host_model.sv ***
// bus host model: start, stop, byte send and receive on an open-drain line.
// assumes a pull-up on sda and that the bench ands every pull-down on the line.
`timescale 1ns/100ps
`default_nettype none

module i2c_host_model (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_low
);
  // 26 clocks a bit keeps the bus just under 1 MHz
  localparam int HALF = 13;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // data moves 3 clocks after scl falls so the target never sees it race
  // the clock through its synchronisers
  task automatic bit_io(input logic b, output logic s);
    tick(3);
    sda_low = ~b;
    tick(HALF - 3);
    scl = 1'b1;
    tick(HALF);
    s = sda_line;
    scl = 1'b0;
  endtask

  // serves as repeated start as well
  task automatic start();
    tick(3);
    sda_low = 1'b0;
    tick(HALF - 3);
    scl = 1'b1;
    tick(HALF);
    sda_low = 1'b1;
    tick(HALF);
    scl = 1'b0;
  endtask

  task automatic stop();
    tick(3);
    sda_low = 1'b1;
    tick(HALF - 3);
    scl = 1'b1;
    tick(HALF);
    sda_low = 1'b0;
    tick(HALF);
  endtask

  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // more high: acknowledge and ask for another byte
  task automatic recv(input logic more, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~more, s);
  endtask
endmodule

`default_nettype wire

// *** dv/i2c_register_access_port_test.sv ***
// self-checking bench for the serial register access port.
// assumes the host model file and the design files are compiled first.
`timescale 1ns/100ps
`default_nettype none

module i2c_register_access_port_test;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr_ready = 1'b1;
  logic [7:0]  rd_data = 8'h00;
  logic        scl;
  logic        sda_low;
  logic        sda_out;
  logic        sda_oe;
  logic        wr_valid;
  logic        rd_req;
  logic        update_hold;
  logic        busy;
  logic [7:0]  wr_addr;
  logic [7:0]  wr_data;
  logic [7:0]  rd_addr;
  // the alternate build's sink never drains, so its one word stays on view
  logic        wr_ready_alt = 1'b0;
  logic        sda_out_alt;
  logic        sda_oe_alt;
  logic        wr_valid_alt;
  logic [7:0]  wr_addr_alt;
  logic [7:0]  wr_data_alt;
  wire         sda_line;
  int          mismatches = 0;
  int          n_checks = 0;
  logic [15:0] words[$];

  always #20 clk = ~clk;
  assign sda_line = ~(sda_low | (sda_oe & ~sda_out) |
                      (sda_oe_alt & ~sda_out_alt));

  i2c_register_access_port dut (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_addr(wr_addr), .wr_data(wr_data),
    .rd_req(rd_req), .rd_addr(rd_addr), .rd_data(rd_data),
    .update_hold(update_hold), .busy(busy)
  );
  i2c_host_model host (
    .clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low)
  );
  // a second target, built as the alternate variant, shares the bus
  i2c_register_access_port #(.ALT_VARIANT(1'b1)) dut_alt (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out_alt), .sda_oe(sda_oe_alt), .wr_valid(wr_valid_alt),
    .wr_ready(wr_ready_alt), .wr_addr(wr_addr_alt), .wr_data(wr_data_alt),
    .rd_req(), .rd_addr(), .rd_data(rd_data),
    .update_hold(), .busy()
  );

  ////////////////////////////////////////////////////////////////////////////
  // register side: fixed pattern per address, words logged as they pop
  function automatic logic [7:0] exp_reg(input logic [7:0] a);
    return a ^ 8'h5a;
  endfunction
  always @(negedge clk) begin
    if (rd_req === 1'b1) rd_data <= exp_reg(rd_addr);
  end
  always @(posedge clk) begin
    if (wr_valid && wr_ready) words.push_back({wr_addr, wr_data});
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check1(input string what, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %b seen %b", what, e, g);
    end
  endtask

  task automatic check8(input string what, input logic [7:0] e,
                        input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic wait_words(input int n);
    int k = 0;
    while (words.size() < n && k < 200) begin
      @(posedge clk);
      k++;
    end
  endtask

  task automatic open_ptr(input logic [7:0] ptr);
    logic ack;
    host.start();
    host.send({7'h34, 1'b0}, ack);
    check1("addr ack", 1'b1, ack);
    host.send(ptr, ack);
    check1("ptr ack", 1'b1, ack);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic s_write_single();
    logic ack;
    words.delete();
    open_ptr(8'h40);
    check1("hold off range", 1'b0, update_hold);
    host.send(8'hc3, ack);
    check1("data ack", 1'b1, ack);
    host.stop();
    wait_words(1);
    check8("word ptr", 8'h40, words[0][15:8]);
    check8("word data", 8'hc3, words[0][7:0]);
    check1("busy after stop", 1'b0, busy);
  endtask

  // sink stalls: fifth byte finds the fifo full; pointer wraps past 0xff
  task automatic s_fifo_full();
    logic ack;
    @(negedge clk) wr_ready = 1'b0;
    words.delete();
    open_ptr(8'hfd);
    for (int i = 0; i < 5; i++) begin
      host.send(8'h10 + 8'(i), ack);
      check1("fill ack", i < 4, ack);
    end
    host.stop();
    check1("fifo holds", 1'b1, wr_valid);
    @(negedge clk) wr_ready = 1'b1;
    wait_words(4);
    for (int i = 0; i < 4; i++) begin
      check8("seq ptr", 8'hfd + 8'(i), words[i][15:8]);
      check8("seq data", 8'h10 + 8'(i), words[i][7:0]);
    end
    repeat (3) @(negedge clk);
    check8("drained", 8'h04, 8'(words.size()));
    check1("fifo empty", 1'b0, wr_valid);
  endtask

  // pointer ends on 0x12, still in the queue range, so only the stop frees it
  task automatic s_read_multi();
    logic       ack;
    logic [7:0] d;
    words.delete();
    open_ptr(8'h0f);
    check1("hold in range", 1'b1, update_hold);
    host.start();
    host.send({7'h34, 1'b1}, ack);
    check1("read addr ack", 1'b1, ack);
    for (int i = 0; i < 3; i++) begin
      host.recv(i < 2, d);
      check8("read byte", exp_reg(8'h0f + 8'(i)), d);
    end
    check1("hold during read", 1'b1, update_hold);
    host.stop();
    repeat (3) @(negedge clk);
    check1("hold released", 1'b0, update_hold);
    check8("no writes", 8'h00, 8'(words.size()));
    // a bare read carries on from the pointer left behind
    host.start();
    host.send({7'h34, 1'b1}, ack);
    check1("bare addr ack", 1'b1, ack);
    host.recv(1'b0, d);
    check8("bare read", exp_reg(8'h12), d);
    host.stop();
  endtask

  task automatic s_foreign();
    logic       ack;
    logic [6:0] bad[2] = '{7'h35, 7'h31};
    words.delete();
    for (int i = 0; i < 2; i++) begin
      host.start();
      host.send({bad[i], 1'b0}, ack);
      check1("foreign ack", 1'b0, ack);
      host.send(8'h22, ack);
      check1("ignored byte", 1'b0, ack);
      host.stop();
    end
    check8("foreign writes", 8'h00, 8'(words.size()));
  endtask

  // the alternate build answers 0x30 while the standard one stays out
  task automatic s_alt_variant();
    logic ack;
    words.delete();
    check1("alt fifo empty", 1'b0, wr_valid_alt);
    host.start();
    host.send({7'h30, 1'b0}, ack);
    check1("alt addr ack", 1'b1, ack);
    host.send(8'h07, ack);
    check1("alt ptr ack", 1'b1, ack);
    host.send(8'h99, ack);
    check1("alt data ack", 1'b1, ack);
    host.stop();
    repeat (3) @(negedge clk);
    check1("alt word", 1'b1, wr_valid_alt);
    check8("alt word ptr", 8'h07, wr_addr_alt);
    check8("alt word data", 8'h99, wr_data_alt);
    check8("std ignores alt", 8'h00, 8'(words.size()));
  endtask

  // bus stalls mid-access: the hold must lapse after 575 clocks
  task automatic s_hold_timeout();
    open_ptr(8'h05);
    check1("hold on", 1'b1, update_hold);
    repeat (565) @(negedge clk);
    check1("hold before limit", 1'b1, update_hold);
    repeat (25) @(negedge clk);
    check1("hold after limit", 1'b0, update_hold);
    host.stop();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    check1("idle oe", 1'b0, sda_oe);
    s_write_single();
    s_fifo_full();
    s_read_multi();
    s_foreign();
    s_alt_variant();
    s_hold_timeout();
    complete_run();
  end

  // the whole run needs about 7600 clocks
  initial begin
    repeat (40000) @(posedge clk);
    mismatches++;
    complete_run();
  end
endmodule

`default_nettype wire
